//--- core/e1_rx_alarm_change_irq.sv
/*
  change-flag status, enable and mask registers for four receive e1 alarm
  conditions, reached over AXI4-Lite, with one level interrupt output.
  assumes the condition levels come from the framer on clk_i; they still pass
  two flip-flops since their source may sit on another clock.
*/
// Our own choices: the address map and the AXI4-Lite slave port.
module e1_rx_alarm_change_irq #(
  parameter int NSRC = e1_rx_alarm_pkg::NUM_SRC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic rx_signal_loss_i,
  input wire logic crc_multiframe_lock_i,
  input wire logic cas_multiframe_lock_i,
  input wire logic ts16_all_ones_alarm_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_o
);
  logic [NSRC-1:0] cond_raw;
  logic [NSRC-1:0] sync1_r;
  logic [NSRC-1:0] sync2_r;
  logic [NSRC-1:0] prev_r;
  logic [NSRC-1:0] change;
  logic [NSRC-1:0] flags_r;
  logic [NSRC-1:0] flags_nxt;
  logic [NSRC-1:0] enable_n_r;
  logic [NSRC-1:0] mask_r;
  logic [7:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic w_have_r;
  logic wlane0_r;
  logic do_write;
  logic do_read;
  logic status_read;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;

  assign cond_raw = {rx_signal_loss_i, crc_multiframe_lock_i, cas_multiframe_lock_i, ts16_all_ones_alarm_i};

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      sync1_r <= cond_raw;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // prev_r starts at zero, so a condition already present at release counts as a change
  assign change = sync2_r ^ prev_r;

  assign do_read = s_axi_arvalid && s_axi_arready;
  assign status_read = do_read && (s_axi_araddr[7:2] == e1_rx_alarm_pkg::STATUS_OFS[7:2]);

  generate
    for (genvar i = 0; i < NSRC; i++)
    begin : g_flag
      // a change in the read cycle survives: set wins over clear
      assign flags_nxt[i] = change[i] | (flags_r[i] & ~status_read);
    end
  endgenerate

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flags_r <= e1_rx_alarm_pkg::FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  // write side: address and data captured independently, in either order
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      if (do_write)
        aw_have_r <= 1'b0;
      else if (s_axi_awvalid && !aw_have_r && !s_axi_awready)
        s_axi_awready <= 1'b1;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wlane0_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= 1'b0;
      if (do_write)
        w_have_r <= 1'b0;
      else if (s_axi_wvalid && !w_have_r && !s_axi_wready)
        s_axi_wready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wlane0_r <= s_axi_wstrb[0];
      end
    end
  end

  // only byte lane 0 carries register bits; a write without it is answered but changes nothing
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      enable_n_r <= e1_rx_alarm_pkg::ENABLE_RST;
      mask_r <= e1_rx_alarm_pkg::MASK_RST;
    end
    else if (do_write && wlane0_r)
    begin
      if (awaddr_r[7:2] == e1_rx_alarm_pkg::ENABLE_OFS[7:2])
        enable_n_r <= wdata_r[NSRC-1:0];
      if (awaddr_r[7:2] == e1_rx_alarm_pkg::MASK_OFS[7:2])
        mask_r <= wdata_r[NSRC-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= e1_rx_alarm_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      // status is read-only; writes to it are accepted and ignored
      if (awaddr_r[7:2] == e1_rx_alarm_pkg::STATUS_OFS[7:2] || awaddr_r[7:2] == e1_rx_alarm_pkg::ENABLE_OFS[7:2]
          || awaddr_r[7:2] == e1_rx_alarm_pkg::MASK_OFS[7:2])
        s_axi_bresp <= e1_rx_alarm_pkg::RESP_OKAY;
      else
        s_axi_bresp <= e1_rx_alarm_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read side
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = e1_rx_alarm_pkg::RESP_OKAY;
    if (s_axi_araddr[7:2] == e1_rx_alarm_pkg::STATUS_OFS[7:2])
    begin
      rdata_nxt[NSRC-1:0] = flags_r;
      rdata_nxt[e1_rx_alarm_pkg::TS16_ALL_ONES_ALARM_STATE_STATE_BIT] = sync2_r[e1_rx_alarm_pkg::TS16_ALL_ONES_ALARM_STATE_CHG_BIT];
    end
    else if (s_axi_araddr[7:2] == e1_rx_alarm_pkg::ENABLE_OFS[7:2])
      rdata_nxt[NSRC-1:0] = enable_n_r;
    else if (s_axi_araddr[7:2] == e1_rx_alarm_pkg::MASK_OFS[7:2])
      rdata_nxt[NSRC-1:0] = mask_r;
    else
      rresp_nxt = e1_rx_alarm_pkg::RESP_SLVERR;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= e1_rx_alarm_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rresp_nxt;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // enable bits are active low, the mask bits active high (1 = pass)
  // built from flags_nxt so the request rises in the same cycle as the flag it reports
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(flags_nxt & ~enable_n_r & mask_r);
  end

  // checks watch the synchronised levels; the pins themselves lead them by two cycles
  AST_LOS_EDGE_SETS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(sync2_r[e1_rx_alarm_pkg::LOS_CHG_BIT]) |=> flags_r[e1_rx_alarm_pkg::LOS_CHG_BIT])
    else $error("loss flag not set after condition change");
  AST_CRC_EDGE_SETS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(sync2_r[e1_rx_alarm_pkg::CRC_CHG_BIT]) |=> flags_r[e1_rx_alarm_pkg::CRC_CHG_BIT])
    else $error("crc lock flag not set after change");
  AST_CAS_EDGE_SETS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(sync2_r[e1_rx_alarm_pkg::CAS_CHG_BIT]) |=> flags_r[e1_rx_alarm_pkg::CAS_CHG_BIT])
    else $error("cas lock flag not set after change");
  AST_TS16_EDGE_SETS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(sync2_r[e1_rx_alarm_pkg::TS16_ALL_ONES_ALARM_STATE_CHG_BIT]) |=> flags_r[e1_rx_alarm_pkg::TS16_ALL_ONES_ALARM_STATE_CHG_BIT])
    else $error("ts16 flag not set after alarm change");
  AST_FLAG_CLEARS_ON_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (status_read && change == '0) |=> flags_r == '0)
    else $error("flags not cleared by status read");
  AST_FLAG_HOLDS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!status_read) |=> (($past(flags_r) & ~flags_r) == '0))
    else $error("flag dropped without a read");
  AST_FLAG_SETS_ONLY_ON_CHANGE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (change == '0) |=> ((flags_r & ~$past(flags_r)) == '0))
    else $error("flag set without a condition change");
  AST_STATE_BIT_LIVE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (status_read) |=> s_axi_rdata[e1_rx_alarm_pkg::TS16_ALL_ONES_ALARM_STATE_STATE_BIT] == $past(sync2_r[0]))
    else $error("ts16 state bit wrong on read");
  AST_DISABLED_NO_IRQ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (enable_n_r == 4'hF) |=> !irq_o)
    else $error("interrupt with all sources disabled");
  AST_IRQ_OR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    irq_o == |($past(flags_nxt) & ~$past(enable_n_r) & $past(mask_r)))
    else $error("interrupt not OR of enabled flags");
  AST_ENABLE_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (do_write && wlane0_r && awaddr_r[7:2] == e1_rx_alarm_pkg::ENABLE_OFS[7:2]) |=> enable_n_r == $past(wdata_r[3:0]))
    else $error("enable register not written");
  AST_IRQ_DROPS_AFTER_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (status_read && change == '0) |=> !irq_o)
    else $error("interrupt still high after flags were read");

  // each enable bit must gate its own source only; a miswired bit shows up as a wrong request
  AST_LOS_EN_GATES: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flags_nxt == 4'h8 && mask_r[3]) |=> irq_o == !$past(enable_n_r[3]))
    else $error("loss enable bit does not gate the interrupt");
  AST_CRC_EN_GATES: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flags_nxt == 4'h4 && mask_r[2]) |=> irq_o == !$past(enable_n_r[2]))
    else $error("crc enable bit does not gate the interrupt");
  AST_CAS_EN_GATES: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flags_nxt == 4'h2 && mask_r[1]) |=> irq_o == !$past(enable_n_r[1]))
    else $error("cas enable bit does not gate the interrupt");
  AST_TS16_EN_GATES: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flags_nxt == 4'h1 && mask_r[0]) |=> irq_o == !$past(enable_n_r[0]))
    else $error("ts16 enable bit does not gate the interrupt");

  COV_LOS_IRQ: cover property (@(posedge clk_i) disable iff (!nrst_i) change[3] ##[1:4] irq_o);
  COV_READ_CLEAR: cover property (@(posedge clk_i) disable iff (!nrst_i) flags_r[2] ##1 status_read ##1 !flags_r[2]);
  COV_SET_ON_READ: cover property (@(posedge clk_i) disable iff (!nrst_i) status_read && change != '0);
  COV_ERR_READ: cover property (@(posedge clk_i) disable iff (!nrst_i) s_axi_rvalid && s_axi_rresp != 2'h0);
  COV_ALL_DISABLED: cover property (@(posedge clk_i) disable iff (!nrst_i) enable_n_r == 4'hF && change != '0);
endmodule

//--- include/e1_rx_alarm_pkg.sv
/*
  register map, bit positions and reset values of the receive alarm change block.
  assumes a 32-bit aligned AXI4-Lite register bus; offsets are byte addresses.
*/
package e1_rx_alarm_pkg;
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] ENABLE_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam int TS16_ALL_ONES_ALARM_STATE_CHG_BIT = 0;
  localparam int CAS_CHG_BIT = 1;
  localparam int CRC_CHG_BIT = 2;
  localparam int LOS_CHG_BIT = 3;
  localparam int TS16_ALL_ONES_ALARM_STATE_STATE_BIT = 4;
  localparam int NUM_SRC = 4;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verification/test_e1_rx_alarm_change_irq.sv
/*
  self-checking bench for e1_rx_alarm_change_irq: register tests over axi4-lite.
  assumes one 20 MHz clock and the offsets and codes of e1_rx_alarm_pkg.
*/
module test_e1_rx_alarm_change_irq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ST = e1_rx_alarm_pkg::STATUS_OFS;
  localparam logic [7:0] EN = e1_rx_alarm_pkg::ENABLE_OFS;
  localparam logic [7:0] MK = e1_rx_alarm_pkg::MASK_OFS;
  localparam logic [1:0] OK = e1_rx_alarm_pkg::RESP_OKAY;
  localparam logic [1:0] ER = e1_rx_alarm_pkg::RESP_SLVERR;
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [3:0] cond = 4'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_o;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0;
  int checks_done = 0;

  e1_rx_alarm_change_irq u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .rx_signal_loss_i(cond[3]), .crc_multiframe_lock_i(cond[2]),
    .cas_multiframe_lock_i(cond[1]), .ts16_all_ones_alarm_i(cond[0]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_o(irq_o));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // starts on a fresh edge so a release at the previous edge is never overwritten
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk_i);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk_i);
      if (arready === 1'h1) arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'h1;
    rdc(ST, 32'h0, OK);
    rdc(EN, 32'h0, OK);
    rdc(MK, 32'h0, OK);
    wr(EN, 32'hA, OK);
    rdc(EN, 32'hA, OK);
    wr(MK, 32'hF, OK);
    for (int i = 0; i < 4; i++)
    begin
      for (int e = 0; e < 3; e++)
      begin
        // e=1 disables only the source under test, so each enable bit must be wired to its own flag
        wr(EN, (e == 0) ? 32'h0 : ((e == 1) ? (32'h1 << i) : 32'hF), OK);
        for (int k = 0; k < 2; k++)
        begin
          cond[i] <= ~cond[i];
          repeat (5) @(posedge clk_i);
          chk({31'h0, irq_o}, (e == 0) ? 32'h1 : 32'h0);
          rdc(ST, (32'(cond[0]) << 4) | (32'h1 << i), OK);
          rdc(ST, 32'(cond[0]) << 4, OK);
          chk({31'h0, irq_o}, 32'h0);
        end
      end
    end
    wr(EN, 32'h0, OK);
    wr(MK, 32'h0, OK);
    cond <= 4'h1;
    repeat (5) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(MK, 32'hF, OK);
    // the request follows the mask write one edge after the response
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(ST, 32'hFF, OK);
    rdc(ST, 32'h11, OK);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h0C, 32'h5, ER);
    rdc(8'h0C, 32'h0, ER);
    stop_test();
  end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    stop_test();
  end
endmodule
